// ---- codec_host_parallel_port.sv ----
// byte-wide strobe-driven host port with register and DMA sample paths
`timescale 1ns/1ps
module codec_host_parallel_port #(
   parameter int SAMPLE_BYTES = host_port_pkg::SAMPLE_BYTES
) (
   input wire logic clock,
   input wire logic resetn,
   // host pins
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chip_select_n,
   input wire logic capture_ack_n,
   input wire logic playback_ack_n,
   input wire logic [host_port_pkg::SEL_W-1:0] register_select,
   input wire logic [host_port_pkg::DATA_W-1:0] host_data_in,
   output logic [host_port_pkg::DATA_W-1:0] host_data_out,
   output logic host_data_oe_n,
   output logic capture_request,
   output logic playback_request,
   output logic buffer_enable_n,
   output logic buffer_direction,
   // register side
   output logic reg_read_stb,
   output logic reg_write_stb,
   output logic [host_port_pkg::SEL_W-1:0] reg_select_q,
   output logic [host_port_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [host_port_pkg::DATA_W-1:0] reg_rdata,
   // sample side
   input wire logic cap_load,
   input wire logic [host_port_pkg::DATA_W*SAMPLE_BYTES-1:0] cap_sample,
   output logic cap_ready,
   input wire logic pb_space,
   output logic pb_valid,
   output logic [host_port_pkg::DATA_W*SAMPLE_BYTES-1:0] pb_sample
);
   import host_port_pkg::*;

   localparam int IDX_W = (SAMPLE_BYTES > 1) ? $clog2(SAMPLE_BYTES) : 1;
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(SAMPLE_BYTES - 1);
   localparam int SW = DATA_W * SAMPLE_BYTES;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [14:0] pins_s;
   logic rd_s, wr_s, cs_s, cak_s, pak_s;
   logic [SEL_W-1:0] sel_s;
   logic [DATA_W-1:0] data_s;

   host_port_sync #(.WIDTH(15), .RESET_VALUE(PIN_RESET)) u_sync (
      .clock(clock),
      .resetn(resetn),
      .async_in({read_strobe_n, write_strobe_n, chip_select_n, capture_ack_n,
                 playback_ack_n, register_select, host_data_in}),
      .sync_out(pins_s)
   );

   assign {rd_s, wr_s, cs_s, cak_s, pak_s, sel_s, data_s} = pins_s;

   // ------------------------------------------------------------
   // cycle qualification
   // ------------------------------------------------------------
   logic dma_rd, dma_wr, reg_rd, reg_wr, no_ack;
   always_comb begin
      no_ack = cak_s & pak_s;
      dma_rd = !rd_s & !cak_s;
      dma_wr = !wr_s & !pak_s;
      reg_rd = !rd_s & !cs_s & no_ack;
      reg_wr = !wr_s & !cs_s & no_ack;
   end

   function automatic logic is_read(input cycle_state_t s);
      return (s == S_REG_RD) || (s == S_CAP_RD);
   endfunction : is_read

   // ------------------------------------------------------------
   // cycle state and pin drivers
   // ------------------------------------------------------------
   cycle_state_t state_q, state_d;
   logic [DATA_W-1:0] dout_d, wbyte_q, wbyte_d;
   logic oe_n_d, ben_d, dir_d, rstb_d, wstb_d;
   logic [SEL_W-1:0] sel_d;
   logic cap_done, pb_done;
   logic [SW-1:0] cap_buf_q, cap_buf_d, pb_buf_q, pb_buf_d, pb_sample_d;
   logic [IDX_W-1:0] cap_idx_q, cap_idx_d, pb_idx_q, pb_idx_d;
   logic cap_req_d, pb_req_d, pb_valid_d;

   always_comb begin
      state_d = state_q;
      wbyte_d = wbyte_q;
      sel_d = reg_select_q;
      rstb_d = 1'b0;
      wstb_d = 1'b0;
      cap_done = 1'b0;
      pb_done = 1'b0;
      case (state_q)
         S_IDLE: begin
            // DMA acks take priority; chip select is then irrelevant
            if (dma_rd) begin
               state_d = S_CAP_RD;
            end else if (dma_wr) begin
               state_d = S_PB_WR;
            end else if (reg_rd) begin
               state_d = S_REG_RD;
               sel_d = sel_s;
               rstb_d = 1'b1;
            end else if (reg_wr) begin
               state_d = S_REG_WR;
               sel_d = sel_s;
            end
         end
         S_REG_RD, S_CAP_RD: begin
            if (rd_s) begin
               state_d = S_IDLE;
               cap_done = (state_q == S_CAP_RD);
            end
         end
         S_PB_WR, S_REG_WR: begin
            // keep the last byte seen while the strobe was low
            if (wr_s) begin
               state_d = S_IDLE;
               pb_done = (state_q == S_PB_WR);
               wstb_d = (state_q == S_REG_WR);
            end else begin
               wbyte_d = data_s;
            end
         end
         default: state_d = S_IDLE;
      endcase
      ben_d = (state_d == S_IDLE);
      dir_d = !is_read(state_d);
      oe_n_d = !is_read(state_d);
      if (state_d == S_CAP_RD) begin
         dout_d = cap_buf_q[DATA_W*cap_idx_q +: DATA_W];
      end else if (state_d == S_REG_RD) begin
         dout_d = reg_rdata;
      end else begin
         dout_d = host_data_out;
      end
   end

   // ------------------------------------------------------------
   // capture and playback sample buffers
   // ------------------------------------------------------------
   always_comb begin
      cap_buf_d = cap_buf_q;
      cap_idx_d = cap_idx_q;
      cap_req_d = capture_request;
      if (cap_done && capture_request) begin
         if (cap_idx_q == LAST_IDX) begin
            cap_req_d = 1'b0;
         end else begin
            cap_idx_d = cap_idx_q + 1'b1;
         end
      end else if (cap_load && !capture_request) begin
         cap_buf_d = cap_sample;
         cap_idx_d = '0;
         cap_req_d = 1'b1;
      end
      pb_buf_d = pb_buf_q;
      pb_idx_d = pb_idx_q;
      pb_req_d = playback_request;
      pb_valid_d = 1'b0;
      pb_sample_d = pb_sample;
      if (pb_done && playback_request) begin
         pb_buf_d[DATA_W*pb_idx_q +: DATA_W] = wbyte_q;
         if (pb_idx_q == LAST_IDX) begin
            pb_req_d = 1'b0;
            pb_idx_d = '0;
            pb_valid_d = 1'b1;
            pb_sample_d = pb_buf_d;
         end else begin
            pb_idx_d = pb_idx_q + 1'b1;
         end
      end else if (!playback_request && pb_space) begin
         pb_req_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_q <= S_IDLE;
         wbyte_q <= BYTE_RESET;
         host_data_out <= BYTE_RESET;
         host_data_oe_n <= 1'b1;
         buffer_enable_n <= 1'b1;
         buffer_direction <= 1'b1;
         reg_read_stb <= 1'b0;
         reg_write_stb <= 1'b0;
         reg_select_q <= SEL_RESET;
         reg_wdata <= BYTE_RESET;
         cap_buf_q <= '0;
         cap_idx_q <= '0;
         capture_request <= 1'b0;
         cap_ready <= 1'b1;
         pb_buf_q <= '0;
         pb_idx_q <= '0;
         playback_request <= 1'b0;
         pb_valid <= 1'b0;
         pb_sample <= '0;
      end else begin
         state_q <= state_d;
         wbyte_q <= wbyte_d;
         host_data_out <= dout_d;
         host_data_oe_n <= oe_n_d;
         buffer_enable_n <= ben_d;
         buffer_direction <= dir_d;
         reg_read_stb <= rstb_d;
         reg_write_stb <= wstb_d;
         reg_select_q <= sel_d;
         reg_wdata <= wstb_d ? wbyte_q : reg_wdata;
         cap_buf_q <= cap_buf_d;
         cap_idx_q <= cap_idx_d;
         capture_request <= cap_req_d;
         cap_ready <= !cap_req_d;
         pb_buf_q <= pb_buf_d;
         pb_idx_q <= pb_idx_d;
         playback_request <= pb_req_d;
         pb_valid <= pb_valid_d;
         pb_sample <= pb_sample_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   chk_dma_rd_enable: assert property (
      state_q == S_IDLE && !rd_s && !cak_s |=> state_q == S_CAP_RD && !buffer_enable_n)
      else $error("DMA read did not enable the transceiver");
   chk_dma_ignores_cs: assert property (
      state_q == S_IDLE && !wr_s && !pak_s && cs_s && rd_s |=> state_q == S_PB_WR)
      else $error("DMA write was blocked by chip select");
   chk_cs_required: assert property (
      state_q == S_IDLE && cs_s && no_ack |=> buffer_enable_n && !reg_read_stb)
      else $error("register strobe taken without chip select");
   chk_dir_rest: assert property (
      buffer_enable_n |-> buffer_direction && host_data_oe_n)
      else $error("direction or data drive active while idle");
   chk_dir_read_only: assert property (
      !buffer_direction |-> $past(!rd_s) && !buffer_enable_n)
      else $error("direction low outside a read");
   chk_drive_read: assert property (
      !host_data_oe_n |-> is_read(state_q) && $past(!rd_s))
      else $error("data bus driven outside a read cycle");
   chk_cap_raise: assert property (
      cap_load && !capture_request |=> capture_request ##1 !cap_ready)
      else $error("capture request not raised on load");
   chk_cap_hold: assert property (
      capture_request && !cap_done |=> capture_request)
      else $error("capture request dropped before all bytes read");
   chk_cap_drop: assert property (
      capture_request && cap_done && cap_idx_q == LAST_IDX |=> !capture_request)
      else $error("capture request held after last byte");
   chk_pb_done: assert property (
      playback_request && pb_done && pb_idx_q == LAST_IDX |=> !playback_request && pb_valid)
      else $error("playback request not ended after full sample");
   chk_pb_hold: assert property (
      playback_request && !pb_done |=> playback_request)
      else $error("playback request dropped mid sample");
   chk_reg_wr_pulse: assert property (
      reg_write_stb |=> !reg_write_stb && state_q == S_IDLE)
      else $error("register write strobe longer than one cycle");

   cov_cap_sample: cover property (capture_request ##[1:200] !capture_request);
   cov_pb_sample: cover property (pb_valid);
   cov_reg_read: cover property (reg_read_stb ##[1:20] buffer_enable_n);
   cov_reg_write: cover property (reg_write_stb);
endmodule : codec_host_parallel_port

// ---- host_bus_model.sv ----
// host bus and DMA controller model driving the codec host pins
`timescale 1ns/1ps
module host_bus_model (
   input wire logic clock,
   input wire logic [7:0] bus_level,
   input wire logic buffer_enable_n,
   input wire logic buffer_direction,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic chip_select_n,
   output logic capture_ack_n,
   output logic playback_ack_n,
   output logic [1:0] register_select,
   output logic drive_en,
   output logic [7:0] drive_val
);
   initial begin
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      chip_select_n = 1'b1;
      capture_ack_n = 1'b1;
      playback_ack_n = 1'b1;
      register_select = 2'h0;
      drive_en = 1'b0;
      drive_val = 8'h00;
   end
   // ---------------------------------------------
   // one bus cycle, qualifiers set a clock ahead
   // ---------------------------------------------
   task automatic cycle(input logic rd, input logic cs_n, input logic cak_n,
         input logic pak_n, input logic [1:0] sel, input logic [7:0] wd,
         output logic [7:0] rv, output logic en_seen, output logic dir_seen);
      @(posedge clock);
      chip_select_n <= cs_n;
      capture_ack_n <= cak_n;
      playback_ack_n <= pak_n;
      register_select <= sel;
      drive_en <= !rd;
      drive_val <= wd;
      @(posedge clock);
      read_strobe_n <= !rd;
      write_strobe_n <= rd;
      repeat (6) @(posedge clock);
      rv = bus_level;
      en_seen = buffer_enable_n;
      dir_seen = buffer_direction;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      // acks and data outlive the strobe, as the sync delay needs
      repeat (3) @(posedge clock);
      chip_select_n <= 1'b1;
      capture_ack_n <= 1'b1;
      playback_ack_n <= 1'b1;
      drive_en <= 1'b0;
      register_select <= ~sel;
      repeat (4) @(posedge clock);
   endtask : cycle
endmodule : host_bus_model

// ---- host_port_sync.sv ----
// constants for the codec host port, and the pin synchroniser
//
// Function
// - raise capture request when sample ready
// - hold capture request until all bytes read
// - capture ack with read means DMA read
// - raise playback request when space exists
// - hold playback request until sample written
// - playback ack with write means DMA write
// - register select picks the direct register
// - read strobe returns register or capture byte
// - write strobe loads register or playback byte
// - register strobes need chip select low
// - chip select ignored during DMA cycles
// - buffer enable low only in qualified cycles
// - direction high for writes and idle
// - direction low only in qualified reads
// - all traffic uses the eight-bit data bus
package host_port_pkg;
   localparam int DATA_W = 8;
   localparam int SEL_W = 2;
   localparam int SAMPLE_BYTES = 4;
   localparam int SYNC_STAGES = 2;
   // pins idle high; data bus idles high through pull-ups
   localparam logic [14:0] PIN_RESET = 15'h7fff;
   localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
   localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

   // ------------------------------------------------------------
   // bus cycle states, gray in listed order idle, reg read, cap read, pb write, reg write
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_REG_RD = 3'h1,
      S_CAP_RD = 3'h3,
      S_PB_WR = 3'h2,
      S_REG_WR = 3'h6
   } cycle_state_t;
endpackage : host_port_pkg

`timescale 1ns/1ps
module host_port_sync #(
   parameter int WIDTH = 15,
   parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_d;

   // first stage is read only by the second stage
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RESET_VALUE;
         sync_out <= RESET_VALUE;
      end else begin
         meta_q <= meta_d;
         sync_out <= sync_d;
      end
   end
endmodule : host_port_sync

// ---- tb_top.sv ----
// self-checking bench for the codec host port
`timescale 1ns/1ps
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
   import host_port_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic read_strobe_n, write_strobe_n, chip_select_n, capture_ack_n, playback_ack_n;
   logic [SEL_W-1:0] register_select, reg_select_q;
   logic [DATA_W-1:0] host_data_in, host_data_out, reg_wdata, reg_rdata, drive_val, rv;
   logic host_data_oe_n, capture_request, playback_request, buffer_enable_n;
   logic buffer_direction, reg_read_stb, reg_write_stb, cap_ready, pb_valid, drive_en;
   logic en_s, dir_s;
   logic cap_load = 1'b0;
   logic pb_space = 1'b0;
   logic [DATA_W*SAMPLE_BYTES-1:0] cap_sample = '0;
   logic [DATA_W*SAMPLE_BYTES-1:0] pb_sample, pb_last;
   int err_total = 0;
   int tests_run = 0;
   int n_rs = 0;
   int n_ws = 0;
   int n_pv = 0;

   always #12.5 clock = ~clock;
   // pull-ups hold the bus high when nobody drives it
   assign host_data_in = !host_data_oe_n ? host_data_out : (drive_en ? drive_val : 8'hff);
   assign reg_rdata = 8'h5a ^ {6'h0, reg_select_q};
   always @(posedge clock) begin
      if (reg_read_stb === 1'b1) n_rs++;
      if (reg_write_stb === 1'b1) n_ws++;
      if (pb_valid === 1'b1) begin
         n_pv++;
         pb_last = pb_sample;
      end
   end

   codec_host_parallel_port dut (.clock(clock), .resetn(resetn),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .chip_select_n(chip_select_n), .capture_ack_n(capture_ack_n),
      .playback_ack_n(playback_ack_n), .register_select(register_select),
      .host_data_in(host_data_in), .host_data_out(host_data_out),
      .host_data_oe_n(host_data_oe_n), .capture_request(capture_request),
      .playback_request(playback_request), .buffer_enable_n(buffer_enable_n),
      .buffer_direction(buffer_direction), .reg_read_stb(reg_read_stb),
      .reg_write_stb(reg_write_stb), .reg_select_q(reg_select_q), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .cap_load(cap_load), .cap_sample(cap_sample),
      .cap_ready(cap_ready), .pb_space(pb_space), .pb_valid(pb_valid),
      .pb_sample(pb_sample));

   host_bus_model host (.clock(clock), .bus_level(host_data_in),
      .buffer_enable_n(buffer_enable_n), .buffer_direction(buffer_direction),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .chip_select_n(chip_select_n), .capture_ack_n(capture_ack_n),
      .playback_ack_n(playback_ack_n), .register_select(register_select),
      .drive_en(drive_en), .drive_val(drive_val));

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_idle();
      `CHK("enable idle", 1'b1, buffer_enable_n)
      `CHK("direction idle", 1'b1, buffer_direction)
      `CHK("oe idle", 1'b1, host_data_oe_n)
      `CHK("cap req idle", 1'b0, capture_request)
      $display("test idle finished");
   endtask : t_idle

   task automatic t_reg();
      for (int s = 0; s < 4; s++) begin
         host.cycle(1'b0, 1'b0, 1'b1, 1'b1, s[1:0], 8'(8'h30 + s), rv, en_s, dir_s);
         `CHK("wr enable", 1'b0, en_s)
         `CHK("wr direction", 1'b1, dir_s)
         `CHK("wr data", 8'(8'h30 + s), reg_wdata)
         `CHK("wr select", s[1:0], reg_select_q)
         `CHK("wr strobes", s + 1, n_ws)
         host.cycle(1'b1, 1'b0, 1'b1, 1'b1, s[1:0], 8'h00, rv, en_s, dir_s);
         `CHK("rd data", 8'h5a ^ 8'(s), rv)
         `CHK("rd enable", 1'b0, en_s)
         `CHK("rd direction", 1'b0, dir_s)
         `CHK("rd strobes", s + 1, n_rs)
         `CHK("rd release", 1'b1, host_data_oe_n)
      end
      $display("test registers finished");
   endtask : t_reg

   task automatic t_no_cs();
      host.cycle(1'b1, 1'b1, 1'b1, 1'b1, 2'h1, 8'h00, rv, en_s, dir_s);
      `CHK("nocs bus", 8'hff, rv)
      `CHK("nocs direction", 1'b1, dir_s)
      host.cycle(1'b0, 1'b1, 1'b1, 1'b1, 2'h2, 8'h77, rv, en_s, dir_s);
      `CHK("nocs enable", 1'b1, en_s)
      `CHK("nocs strobes", 8, n_rs + n_ws)
      $display("test no select finished");
   endtask : t_no_cs

   task automatic t_capture();
      @(posedge clock);
      cap_sample <= 32'h44332211;
      cap_load <= 1'b1;
      @(posedge clock);
      cap_load <= 1'b0;
      repeat (3) @(posedge clock);
      `CHK("cap request", 1'b1, capture_request)
      `CHK("cap ready low", 1'b0, cap_ready)
      for (int b = 0; b < SAMPLE_BYTES; b++) begin
         // select left high: a DMA read must not depend on it
         host.cycle(1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 8'h00, rv, en_s, dir_s);
         `CHK("cap byte", cap_sample[8*b +: 8], rv)
         `CHK("cap enable", 1'b0, en_s)
         `CHK("cap direction", 1'b0, dir_s)
         `CHK("cap hold", b < SAMPLE_BYTES - 1, capture_request)
      end
      `CHK("cap ready back", 1'b1, cap_ready)
      `CHK("cap no reg", 4, n_rs)
      $display("test capture finished");
   endtask : t_capture

   task automatic t_playback();
      @(posedge clock);
      pb_space <= 1'b1;
      repeat (3) @(posedge clock);
      pb_space <= 1'b0;
      `CHK("pb request", 1'b1, playback_request)
      for (int b = 0; b < SAMPLE_BYTES; b++) begin
         // select alternates: the ack wins either way
         host.cycle(1'b0, b[0], 1'b1, 1'b0, 2'h3, 8'(8'h81 + b), rv, en_s, dir_s);
         `CHK("pb enable", 1'b0, en_s)
         `CHK("pb direction", 1'b1, dir_s)
         `CHK("pb hold", b < SAMPLE_BYTES - 1, playback_request)
      end
      // a write with no request pending must be dropped
      host.cycle(1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 8'h99, rv, en_s, dir_s);
      `CHK("pb dropped", 1'b0, playback_request)
      `CHK("pb valid", 1, n_pv)
      `CHK("pb sample", 32'h84838281, pb_last)
      `CHK("pb no reg", 4, n_ws)
      $display("test playback finished");
   endtask : t_playback

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      repeat (3) @(posedge clock);
      t_idle();
      t_reg();
      t_no_cs();
      t_capture();
      t_playback();
      stop_test();
   end

   // about 300 clocks expected; thirteen times that means a hang
   initial begin
      repeat (4000) @(posedge clock);
      err_total++;
      stop_test();
   end
endmodule : tb_top
